// file: hdl/meter_register_access_policy.sv
// Access policy for the meter register map: answers, exceptions, commands.
// Assumes requests arrive pre-classified, one per cycle, synchronous to
// sys_clk, and that the storage layer reports save and range outcomes.
`timescale 1ns/1ps

// What this block does
// - Outside settings mode settings read zero, writes get illegal address.
// - Command registers always read as zero, in every mode.
// - Command writes accepted only in a fitting mode, else illegal address.
// - Wrong password gives a normal response but the command is not run.
// - With passwords disabled, the value 5555 is the accepted password.
// - Writing the save trigger in settings mode commits pending settings to EEPROM.
// - Failed save answers device failure and leaves settings mode by reset.
// - In degraded fallback state, reset commands get illegal function.
// - Wye and delta measure three voltage angles; 2.5 element derives two.
// - A missing phase zeroes its two voltage angles and its current angle.
// - A and C current angles always; B only for wye, zero otherwise.
// - Any settings value out of range keeps the degraded fallback state outside settings mode.
// - Range values marked M are scaled by one million when checked.
// - Unmapped addresses read zero; writes are accepted and change nothing.
module meter_register_access_policy #(
   parameter int unsigned ANGLE_W = 16
) (
   input  wire logic                          sys_clk,
   input  wire logic                          rst_b,
   input  wire meter_access_pkg::req_t        req,
   input  wire logic                          enter_settings,
   input  wire logic                          exit_settings,
   input  wire logic                          password_enabled,
   input  wire logic [15:0]                   password_setting,
   input  wire logic                          settings_out_of_range,
   input  wire logic [31:0]                   range_value,
   input  wire logic                          range_mega,
   input  wire logic                          save_done,
   input  wire logic                          save_error,
   input  wire meter_access_pkg::hookup_t     hookup,
   input  wire logic [2:0]                    phase_present,
   input  wire meter_access_pkg::angles_t     angle_meas,
   output meter_access_pkg::rsp_t             rsp,
   output logic                               save_start,
   output logic                               meter_reset,
   output meter_access_pkg::meter_mode_t      mode,
   output logic [63:0]                        range_scaled,
   output meter_access_pkg::angles_t          angle_out
);

   // ==========================================================================
   // Helpers
   function automatic meter_access_pkg::rsp_t make_exc(
      input logic [7:0] func,
      input logic [7:0] code
   );
      meter_access_pkg::rsp_t r;
      r           = '0;
      r.valid     = 1'b1;
      r.exception = 1'b1;
      r.func      = func | meter_access_pkg::EXC_FLAG;
      r.exc_code  = code;
      return r;
   endfunction : make_exc

   // Angle between a pair is valid only if both phases are present.
   function automatic logic [15:0] keep_if(
      input logic        ok,
      input logic [15:0] v
   );
      return ok ? v : 16'h0000;
   endfunction : keep_if

   // ==========================================================================
   // Mode and response state
   meter_access_pkg::meter_mode_t mode_q, mode_d;
   meter_access_pkg::rsp_t        rsp_q, rsp_d;
   logic                          save_start_q, save_start_d;
   logic                          reset_q, reset_d;
   logic                          save_busy_q, save_busy_d;
   logic [7:0]                    save_func_q, save_func_d;
   logic                          pw_ok;

   assign pw_ok = password_enabled ? (req.wdata == password_setting)
                                   : (req.wdata ==
                                      meter_access_pkg::PASSWORD_DISABLED);

   always_comb begin
      mode_d       = mode_q;
      rsp_d        = '0;
      save_start_d = 1'b0;
      reset_d      = 1'b0;
      save_busy_d  = save_busy_q;
      save_func_d  = save_func_q;
      // Outside settings mode the fallback state is held while any setting is out of range; enter_settings still wins.
      if (settings_out_of_range && mode_q != meter_access_pkg::MODE_SETTING)
      begin
         mode_d = meter_access_pkg::MODE_DEGRADE;
      end else if (mode_q == meter_access_pkg::MODE_DEGRADE) begin
         mode_d = meter_access_pkg::MODE_OPERATE;
      end
      if (enter_settings) begin
         mode_d = meter_access_pkg::MODE_SETTING;
      end else if (exit_settings && mode_q == meter_access_pkg::MODE_SETTING)
      begin
         mode_d = meter_access_pkg::MODE_OPERATE;
      end
      if (save_busy_q && (save_done || save_error)) begin
         save_busy_d = 1'b0;
         rsp_d.valid = 1'b1;
         rsp_d.func  = save_func_q;
         if (save_error) begin
            rsp_d   = make_exc(save_func_q,
                               meter_access_pkg::EXC_DEVICE_FAILURE);
            reset_d = 1'b1;
            mode_d  = meter_access_pkg::MODE_OPERATE;
         end
      end else if (req.valid && !save_busy_q) begin
         rsp_d.valid = 1'b1;
         rsp_d.func  = req.func;
         rsp_d.rdata = meter_access_pkg::READ_ZERO;
         unique case (req.cls)
            meter_access_pkg::CLS_UNMAPPED: begin
               rsp_d.rdata = meter_access_pkg::READ_ZERO;
            end
            meter_access_pkg::CLS_DATA: begin
               if (!req.write &&
                   mode_q == meter_access_pkg::MODE_OPERATE) begin
                  rsp_d.rdata = req.rdata;
               end
            end
            meter_access_pkg::CLS_SETTING: begin
               if (mode_q != meter_access_pkg::MODE_SETTING) begin
                  if (req.write) begin
                     rsp_d = make_exc(req.func,
                        meter_access_pkg::EXC_ILLEGAL_ADDRESS);
                  end
               end else if (!req.write) begin
                  rsp_d.rdata = req.rdata;
               end
            end
            meter_access_pkg::CLS_COMMAND: begin
               // Reads always return zero whatever was written.
               rsp_d.rdata = meter_access_pkg::READ_ZERO;
               if (req.write) begin
                  if (req.is_reset_cmd &&
                      mode_q == meter_access_pkg::MODE_DEGRADE) begin
                     rsp_d = make_exc(req.func,
                        meter_access_pkg::EXC_ILLEGAL_FUNCTION);
                  end else if (!req.cmd_fits_mode) begin
                     rsp_d = make_exc(req.func,
                        meter_access_pkg::EXC_ILLEGAL_ADDRESS);
                  end else begin
                     rsp_d.execute = !req.needs_password || pw_ok;
                  end
               end
            end
            meter_access_pkg::CLS_SAVE: begin
               if (req.write) begin
                  if (mode_q != meter_access_pkg::MODE_SETTING) begin
                     rsp_d = make_exc(req.func,
                        meter_access_pkg::EXC_ILLEGAL_ADDRESS);
                  end else begin
                     // Answer is held back until the EEPROM reports back.
                     rsp_d        = '0;
                     save_start_d = 1'b1;
                     save_busy_d  = 1'b1;
                     save_func_d  = req.func;
                  end
               end
            end
            default: begin
               rsp_d.rdata = meter_access_pkg::READ_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         mode_q       <= meter_access_pkg::MODE_OPERATE;
         rsp_q        <= '0;
         save_start_q <= 1'b0;
         reset_q      <= 1'b0;
         save_busy_q  <= 1'b0;
         save_func_q  <= 8'h00;
      end else begin
         mode_q       <= mode_d;
         rsp_q        <= rsp_d;
         save_start_q <= save_start_d;
         reset_q      <= reset_d;
         save_busy_q  <= save_busy_d;
         save_func_q  <= save_func_d;
      end
   end

   // ==========================================================================
   // Range scaling and phase angles
   meter_access_pkg::angles_t angle_q, angle_d;
   logic [63:0]               scaled_q, scaled_d;

   always_comb begin
      scaled_d = range_mega ? ({32'h0, range_value} *
                               {32'h0, meter_access_pkg::MEGA_SCALE})
                            : {32'h0, range_value};
      angle_d  = angle_meas;
      // Wye and delta pass three measured angles; the 2.5 element derives
      // A-B and B-C from its measured C-A angle upstream of this port.
      if (hookup != meter_access_pkg::HOOK_WYE) begin
         angle_d.i_b = 16'h0000;
      end
      angle_d.v_ab = keep_if(phase_present[0] && phase_present[1],
                             angle_d.v_ab);
      angle_d.v_bc = keep_if(phase_present[1] && phase_present[2],
                             angle_d.v_bc);
      angle_d.v_ca = keep_if(phase_present[2] && phase_present[0],
                             angle_d.v_ca);
      angle_d.i_a  = keep_if(phase_present[0], angle_d.i_a);
      angle_d.i_b  = keep_if(phase_present[1], angle_d.i_b);
      angle_d.i_c  = keep_if(phase_present[2], angle_d.i_c);
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         angle_q  <= '0;
         scaled_q <= 64'h0;
      end else begin
         angle_q  <= angle_d;
         scaled_q <= scaled_d;
      end
   end

   assign rsp          = rsp_q;
   assign save_start   = save_start_q;
   assign meter_reset  = reset_q;
   assign mode         = mode_q;
   assign range_scaled = scaled_q;
   assign angle_out    = angle_q;

endmodule : meter_register_access_policy

// file: hdl/meter_access_pkg.sv
// Shared types and constants for the meter register access policy block.
// Assumes a request decoder in front that has already classified addresses.
package meter_access_pkg;

   // ==========================================================================
   // Modbus codes
   localparam logic [7:0]  EXC_ILLEGAL_FUNCTION = 8'h01;
   localparam logic [7:0]  EXC_ILLEGAL_ADDRESS  = 8'h02;
   localparam logic [7:0]  EXC_DEVICE_FAILURE   = 8'h04;
   localparam logic [7:0]  EXC_FLAG             = 8'h80;
   localparam logic [15:0] PASSWORD_DISABLED    = 16'h15B3;
   localparam logic [15:0] READ_ZERO            = 16'h0000;
   localparam logic [31:0] MEGA_SCALE           = 32'h000F4240;

   // ==========================================================================
   // Register classes and modes
   typedef enum logic [2:0] {
      CLS_UNMAPPED = 3'h0,
      CLS_DATA     = 3'h1,
      CLS_SETTING  = 3'h2,
      CLS_COMMAND  = 3'h3,
      CLS_SAVE     = 3'h4
   } reg_class_t;

   typedef enum logic [1:0] {
      MODE_OPERATE = 2'h0,
      MODE_SETTING = 2'h1,
      MODE_DEGRADE = 2'h3
   } meter_mode_t;

   typedef enum logic [1:0] {
      HOOK_WYE   = 2'h0,
      HOOK_DELTA = 2'h1,
      HOOK_2P5   = 2'h2
   } hookup_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [7:0]  func;
      reg_class_t  cls;
      logic        is_reset_cmd;
      logic        needs_password;
      logic        cmd_fits_mode;
      logic [15:0] wdata;
      logic [15:0] rdata;
   } req_t;

   typedef struct packed {
      logic        valid;
      logic        exception;
      logic [7:0]  func;
      logic [7:0]  exc_code;
      logic [15:0] rdata;
      logic        execute;
   } rsp_t;

   typedef struct packed {
      logic [15:0] v_ab;
      logic [15:0] v_bc;
      logic [15:0] v_ca;
      logic [15:0] i_a;
      logic [15:0] i_b;
      logic [15:0] i_c;
   } angles_t;

endpackage : meter_access_pkg

// file: tb/eeprom_model.sv
// Storage model that answers each save request after a short write time.
// Assumes save_start is a one-cycle pulse from the access policy block.
`timescale 1ns/1ps
module eeprom_model (
   input  wire logic sys_clk,
   input  wire logic rst_b,
   input  wire logic save_start,
   input  wire logic fail,
   output logic      save_done,
   output logic      save_error
);
   // The write takes several cycles so that the pending window is real.
   logic [3:0] busy_q;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_q     <= 4'h0;
         save_done  <= 1'b0;
         save_error <= 1'b0;
      end else begin
         busy_q     <= save_start ? 4'h5 : busy_q - 4'(busy_q != 4'h0);
         save_done  <= busy_q == 4'h1 && !fail;
         save_error <= busy_q == 4'h1 && fail;
      end
   end
endmodule : eeprom_model

// file: tb/access_policy_chk.sv
// Concurrent checks on the access policy block ports.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
module access_policy_chk (
   input wire logic                          sys_clk,
   input wire logic                          rst_b,
   input wire meter_access_pkg::req_t        req,
   input wire logic                          password_enabled,
   input wire logic [15:0]                   password_setting,
   input wire logic                          save_done,
   input wire logic                          save_error,
   input wire meter_access_pkg::hookup_t     hookup,
   input wire meter_access_pkg::rsp_t        rsp,
   input wire logic                          save_start,
   input wire logic                          meter_reset,
   input wire meter_access_pkg::meter_mode_t mode,
   input wire meter_access_pkg::angles_t     angle_out
);
   // ==========================================================================
   // Helpers
   // Requests during a save are dropped, so they stay out of antecedents.
   logic        pend_q;
   logic        take;
   logic        in_set;
   logic        in_deg;
   logic [15:0] pw;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_q <= 1'b0;
      end else begin
         pend_q <= (pend_q || save_start) && !(save_done || save_error);
      end
   end
   assign take   = req.valid && !pend_q && !save_start;
   assign in_set = mode == meter_access_pkg::MODE_SETTING;
   assign in_deg = mode == meter_access_pkg::MODE_DEGRADE;
   assign pw = password_enabled ? password_setting : 16'h15B3;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================================
   // Assertions
   a_set_read:
      assert property (take && !req.write && req.cls == 3'h2 && !in_set
         |=> rsp.valid && rsp.rdata == 16'h0000) else $error("setting read");
   a_set_write:
      assert property (take && req.write && req.cls == 3'h2 && !in_set
         |=> rsp.exception && rsp.exc_code == 8'h02
         && rsp.func == ($past(req.func) | 8'h80)) else $error("setting wr");
   a_cmd_mode:
      assert property (take && req.write && req.cls == 3'h3 && !in_deg
         && !req.cmd_fits_mode |=> rsp.exception && rsp.exc_code == 8'h02)
         else $error("command mode");
   a_pw_wrong:
      assert property (take && req.write && req.cls == 3'h3 && !in_deg
         && req.cmd_fits_mode && req.needs_password && req.wdata != pw
         |=> rsp.valid && !rsp.exception && !rsp.execute) else $error("pw");
   a_deg_reset:
      assert property (take && req.write && req.cls == 3'h3 && in_deg
         && req.is_reset_cmd |=> rsp.exception && rsp.exc_code == 8'h01
         && !rsp.execute) else $error("degraded reset");
   a_save_go:
      assert property (take && req.write && req.cls == 3'h4 && in_set
         |=> save_start) else $error("save start");
   a_save_fail:
      assert property (save_error && pend_q |=> rsp.exception && meter_reset
         && rsp.exc_code == 8'h04 && mode == 2'h0) else $error("save fail");
   a_unmapped:
      assert property (take && req.cls == 3'h0 |=> rsp.valid
         && !rsp.exception && rsp.rdata == 16'h0000) else $error("unmapped");
   a_ib_zero:
      assert property (hookup != meter_access_pkg::HOOK_WYE
         |=> angle_out.i_b == 16'h0000) else $error("b current angle");
endmodule : access_policy_chk
bind meter_register_access_policy access_policy_chk i_chk (.*);

// file: tb/testbench.sv
// Self-checking bench for the meter access policy block.
// Assumes the package, block, checker and storage model compile first.
`timescale 1ns/1ps
module testbench;
   // Flag bits: pe, settings, write, fits, password, reset, exc, execute.
   typedef struct packed {
      logic [7:0] fl; logic [2:0] cls; logic [15:0] wd;
      logic [7:0] code; logic [15:0] rd;
   } row_t;
   logic sys_clk, rst_b, enter_settings, exit_settings, password_enabled;
   logic settings_out_of_range, range_mega, save_done, save_error, fail;
   logic save_start, meter_reset;
   logic [15:0] password_setting;
   logic [31:0] range_value;
   logic [2:0]  phase_present;
   logic [63:0] range_scaled;
   logic        ss, mr;
   int          bad_count, comparisons, cycles;
   row_t        rows[15];
   meter_access_pkg::req_t      req, q;
   meter_access_pkg::rsp_t      rsp, got;
   meter_access_pkg::hookup_t   hookup;
   meter_access_pkg::meter_mode_t mode, md;
   meter_access_pkg::angles_t   angle_meas, angle_out, e;
   meter_register_access_policy i_dut (.*);
   eeprom_model                 i_ee (.*);
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         bad_count++;
         test_done();
      end
   end
   // ==========================================================================
   // Tasks
   task automatic chk(input string n, input logic [95:0] x,
                      input logic [95:0] g);
      comparisons++;
      if (g !== x) begin
         bad_count++;
         $display("unexpected %s: expected %0h, seen %0h", n, x, g);
      end
   endtask : chk
   task automatic send(input meter_access_pkg::req_t r);
      @(posedge sys_clk);
      req <= r;
      {ss, mr} = 2'h0;
      for (int k = 0; k < 16; k++) begin
         @(posedge sys_clk);
         req.valid <= 1'b0;
         #1;
         ss = ss | save_start;
         mr = mr | meter_reset;
         got = rsp;
         md = mode;
         if (rsp.valid === 1'b1) break;
      end
      @(posedge sys_clk);
   endtask : send
   task automatic to_mode(input logic s);
      @(posedge sys_clk);
      enter_settings <= s;
      exit_settings  <= !s;
      @(posedge sys_clk);
      {enter_settings, exit_settings} <= 2'h0;
      @(posedge sys_clk);
   endtask : to_mode
   task automatic test_done;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done
   // ==========================================================================
   // Stimulus
   initial begin
      {rst_b, enter_settings, exit_settings, settings_out_of_range} = 4'h0;
      {password_enabled, range_mega, fail, phase_present} = 6'h07;
      {range_value, password_setting} = {32'h0, 16'h2A3C};
      hookup = meter_access_pkg::HOOK_WYE;
      angle_meas = {16'h1111, 16'h2222, 16'h3333,
                    16'h4444, 16'h5555, 16'h6666};
      req = '0;
      rows = '{'{8'h00, 3'h2, 16'h0, 8'h00, 16'h0},
         '{8'h22, 3'h2, 16'h0, 8'h02, 16'h0},
         '{8'h40, 3'h2, 16'h0, 8'h00, 16'h1234},
         '{8'h00, 3'h3, 16'h0, 8'h00, 16'h0},
         '{8'h40, 3'h3, 16'h0, 8'h00, 16'h0},
         '{8'h22, 3'h3, 16'h0, 8'h02, 16'h0},
         '{8'h31, 3'h3, 16'h0, 8'h00, 16'h0},
         '{8'h39, 3'h3, 16'h15B3, 8'h00, 16'h0},
         '{8'h38, 3'h3, 16'h15B2, 8'h00, 16'h0},
         '{8'h3D, 3'h3, 16'h15B3, 8'h00, 16'h0},
         '{8'hB9, 3'h3, 16'h2A3C, 8'h00, 16'h0},
         '{8'hB8, 3'h3, 16'h15B3, 8'h00, 16'h0},
         '{8'h00, 3'h0, 16'h0, 8'h00, 16'h0},
         '{8'h20, 3'h0, 16'h0, 8'h00, 16'h0},
         '{8'h22, 3'h4, 16'h0, 8'h02, 16'h0}};
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'h1;
      @(posedge sys_clk);
      #1 chk("mode", meter_access_pkg::MODE_OPERATE, mode);
      foreach (rows[i]) begin
         to_mode(rows[i].fl[6]);
         password_enabled <= rows[i].fl[7];
         q = {1'h1, rows[i].fl[5], rows[i].fl[5] ? 8'h06 : 8'h03, rows[i].cls,
              rows[i].fl[2], rows[i].fl[3], rows[i].fl[4], rows[i].wd, 16'h1234};
         send(q);
         chk("valid", 1'h1, got.valid);
         chk("exception", rows[i].fl[1], got.exception);
         chk("execute", rows[i].fl[0], got.execute);
         chk("func", q.func | {rows[i].fl[1], 7'h0}, got.func);
         if (rows[i].fl[1]) begin
            chk("exc_code", rows[i].code, got.exc_code);
         end
         if (!rows[i].fl[5]) chk("rdata", rows[i].rd, got.rdata);
      end
      to_mode(1'h1);
      q = {1'h1, 1'h1, 8'h06, 3'h4, 3'h0, 16'h0, 16'h0};
      send(q);
      chk("save_start", 1'h1, ss);
      chk("exception", 1'h0, got.exception);
      chk("save", {1'h1, 1'h0}, {got.valid, mr});
      to_mode(1'h1);
      fail <= 1'h1;
      send(q);
      chk("exc_code", 8'h04, got.exc_code);
      chk("func", 8'h86, got.func);
      chk("reset", {1'h1, meter_access_pkg::MODE_OPERATE}, {mr, md});
      settings_out_of_range <= 1'h1;
      repeat (3) @(posedge sys_clk);
      #1 chk("mode", meter_access_pkg::MODE_DEGRADE, mode);
      q = {1'h1, 1'h1, 8'h06, 3'h3, 3'h5, 16'h15B3, 16'h0};
      send(q);
      chk("degraded", {1'h1, 8'h01, 1'h0},
          {got.exception, got.exc_code, got.execute});
      settings_out_of_range <= 1'h0;
      for (int h = 0; h < 3; h++) begin
         for (int p = 0; p < 8; p++) begin
            @(posedge sys_clk);
            hookup <= meter_access_pkg::hookup_t'(h);
            phase_present <= 3'(p);
            @(posedge sys_clk);
            e = angle_meas;
            if (p != 7 && p != 3) e.v_ab = 16'h0;
            if (p < 6) e.v_bc = 16'h0;
            if (p != 7 && p != 5) e.v_ca = 16'h0;
            if (p % 2 == 0) e.i_a = 16'h0;
            if (p < 4) e.i_c = 16'h0;
            if (h != 0 || p % 4 < 2) e.i_b = 16'h0;
            #1 chk("angles", e, angle_out);
         end
      end
      range_value <= 32'hFFFFFFFF;
      for (int m = 0; m < 2; m++) begin
         range_mega <= m[0];
         repeat (2) @(posedge sys_clk);
         #1 chk("range", m ? 64'h000F423FFFF0BDC0 : 64'hFFFFFFFF,
                range_scaled);
      end
      test_done();
   end
endmodule : testbench
